// >>> ivc_pkg.sv
// package: register map, field layout and types of the interrupt and wake-up controller
`default_nettype none
package ivc_pkg;

  // ----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_POWER_CONTROL      = 8'h87;
  localparam logic [7:0] IDX_INTERRUPT_FLAGS    = 8'h95;
  localparam logic [7:0] IDX_PORT1_WAKE_MASK    = 8'h96;
  localparam logic [7:0] IDX_PORT3_WAKE_MASK    = 8'hA1;
  localparam logic [7:0] IDX_PRIORITY_LOW_MAIN  = 8'hB8;
  localparam logic [7:0] IDX_PRIORITY_HIGH_MAIN = 8'hB9;
  localparam logic [7:0] IDX_PRIORITY_LOW_EXT   = 8'hBA;
  localparam logic [7:0] IDX_PRIORITY_HIGH_EXT  = 8'hBB;
  localparam logic [7:0] IDX_ENABLE_MAIN        = 8'hA8;
  localparam logic [7:0] IDX_ENABLE_EXT         = 8'hA9;
  localparam logic [7:0] IDX_EXT_CONTROL        = 8'hAA;
  localparam logic [7:0] IDX_STATUS             = 8'hAB;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int         PWR_IDLE_BIT   = 0;
  localparam int         PWR_PD_BIT     = 1;
  localparam int         FLG_RTC_BIT    = 0;
  localparam int         FLG_PNC_BIT    = 1;
  localparam int         FLG_EXT2_BIT   = 2;
  localparam int         EN_GLOBAL_BIT  = 7;
  localparam int         XCT_EDGE0_BIT  = 0;
  localparam int         XCT_EDGE1_BIT  = 1;
  localparam int         XCT_FLAG0_BIT  = 2;
  localparam int         XCT_FLAG1_BIT  = 3;
  localparam int         XCT_SLOWSTOP_BIT = 4;
  localparam logic [7:0] REG_RESET      = 8'h00;

  // ----------------------------------------------------------------
  // sources, slots and vectors
  // ----------------------------------------------------------------
  localparam int         NSLOT      = 15;
  localparam int         NMAIN      = 6;
  localparam int         EXT_BASE   = 7;
  localparam int         NPERIPH    = 9;
  localparam int         SLOT_EXT0  = 0;
  localparam int         SLOT_EXT1  = 2;
  localparam int         SLOT_RTC   = 7;
  localparam int         SLOT_PNC   = 8;
  localparam int         SLOT_EXT2  = 9;
  localparam int         SLOT_PWM   = 13;
  localparam int         PERIPH_PWM = 7;
  localparam logic [7:0] VEC_BASE   = 8'h03;

  typedef enum logic [1:0] {PM_RUN, PM_IDLE, PM_HALT, PM_STOP} ivc_pmode_t;

  typedef struct packed {
    logic [2:0]  ext_s1;
    logic [2:0]  ext_s2;
    logic [2:0]  ext_p;
    logic [15:0] pin_s1;
    logic [15:0] pin_s2;
    logic [15:0] pin_p;
    logic [7:0]  pwr;
    logic [7:0]  p1m;
    logic [7:0]  p3m;
    logic [7:0]  plm;
    logic [7:0]  phm;
    logic [7:0]  ple;
    logic [7:0]  phe;
    logic [7:0]  enm;
    logic [7:0]  ene;
    logic [7:0]  xct;
    logic        ext0f;
    logic        ext1f;
    logic        ext2f;
    logic        pncf;
    logic        rtcf;
    logic [3:0]  svc;
    ivc_pmode_t  pmode;
    logic        hold;
    logic        req;
    logic [3:0]  slot;
    logic [1:0]  lvl;
    logic [7:0]  vec;
    logic        bus_wr;
    logic [7:0]  bus_idx;
    logic [31:0] rdata;
  } ivc_state_t;

endpackage
`default_nettype wire

// >>> ivc_ctrl.sv
// module: fourteen-source interrupt controller with idle, halt and stop wake-up
//
// Behaviour
// - fourteen sources arbitrated over four priority levels
// - idle any enabled; halt timer/pwm/pins; stop pins
// - events set flags regardless of enables
// - vectors 0003..0073, eight apart, fixed order
// - per-source enables plus global enable gate requests
// - equal or higher level in service blocks
// - higher level preempts, preempted resumes afterwards
// - two-bit priority from high and low bits
// - per-pin masks enable pin change and wake
// - pins 0/1 edge or level, pin 2 edge
// - pin change flag on masked pin toggle
// - pin 2, pin change, rtc flags clear on entry
// - flag register write zero clears, one keeps
// - idle wake needs source and global enable
// - idle wake enters service routine at once
// - halt/stop wake needs only source enables or pin masks
// - one instruction runs before entry after halt/stop
// - entry after halt/stop needs global enable, sampling
// - pwm and rtc wake halt when enabled
// - power-down refused while enabled ext pin low
// - power bit 1 halt/stop, bit 0 idle
// - slow stop select chooses stop over halt
`default_nettype none
module ivc_ctrl
  import ivc_pkg::*;
(
  input  wire logic                 SYS_CLK_IN,
  input  wire logic                 RESET_IN,
  input  wire logic                 HSEL_IN,
  input  wire logic [11:0]          HADDR_IN,
  input  wire logic [1:0]           HTRANS_IN,
  input  wire logic                 HWRITE_IN,
  input  wire logic [2:0]           HSIZE_IN,
  input  wire logic [31:0]          HWDATA_IN,
  input  wire logic                 HREADY_IN,
  output logic      [31:0]          HRDATA_OUT,
  output logic                      HREADYOUT_OUT,
  output logic                      HRESP_OUT,
  input  wire logic [2:0]           EXT_PIN_IN,
  input  wire logic [15:0]          PORT_PIN_IN,
  input  wire logic [NPERIPH-1:0]   PERIPH_REQ_IN,
  input  wire logic                 RTC_EVENT_IN,
  input  wire logic                 CPU_ACK_IN,
  input  wire logic                 CPU_RETI_IN,
  input  wire logic                 CPU_INSN_DONE_IN,
  output logic                      IRQ_REQ_OUT,
  output logic      [7:0]           IRQ_VECTOR_OUT,
  output logic      [1:0]           IRQ_LEVEL_OUT,
  output logic                      CPU_IDLE_OUT,
  output logic                      CPU_HALT_OUT,
  output logic                      CPU_STOP_OUT
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic slot_bit(input logic [7:0] m, input logic [7:0] e, input int s);
    logic r;
    r = 1'b0;
    if (s < NMAIN) begin
      r = m[s];
    end else if (s >= EXT_BASE) begin
      r = e[s-EXT_BASE];
    end
    return r;
  endfunction

  function automatic logic [1:0] top_level(input logic [3:0] v);
    logic [1:0] r;
    r = 2'h0;
    for (int i = 0; i < 4; i++) begin
      if (v[i]) begin
        r = 2'(i);
      end
    end
    return r;
  endfunction

  ivc_state_t q;
  ivc_state_t d;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [NSLOT-1:0] flags;
    logic [NSLOT-1:0] pend;
    logic             found;
    logic [3:0]       best;
    logic [1:0]       best_lvl;
    logic [1:0]       lvl_i;
    logic [1:0]       cur_lvl;
    logic             any_svc;
    logic [2:0]       ext_fall;
    logic [15:0]      pin_chg;
    logic             wr;
    logic [7:0]       wd;
    logic             pin_wake;
    logic             halt_wake;
    logic             refuse;
    logic             set_e0;
    logic             set_e1;
    logic             clr_e0;
    logic             clr_e1;
    logic             clr_e2;
    logic             clr_pnc;
    logic             clr_rtc;
    logic [7:0]       rd;
    logic [9:0]       aidx;
    d         = q;
    flags     = '0;
    pend      = '0;
    found     = 1'b0;
    best      = 4'h0;
    best_lvl  = 2'h0;
    lvl_i     = 2'h0;
    rd        = 8'h00;
    aidx      = HADDR_IN[11:2];
    wr        = q.bus_wr;
    wd        = HWDATA_IN[7:0];
    clr_e0    = 1'b0;
    clr_e1    = 1'b0;
    clr_e2    = 1'b0;
    clr_pnc   = 1'b0;
    clr_rtc   = 1'b0;
    cur_lvl   = 2'h0;
    any_svc   = 1'b0;
    ext_fall  = 3'h0;
    pin_chg   = 16'h0000;
    pin_wake  = 1'b0;
    halt_wake = 1'b0;
    refuse    = 1'b0;
    set_e0    = 1'b0;
    set_e1    = 1'b0;

    // pins pass two flops before any use
    d.ext_s1 = EXT_PIN_IN;
    d.ext_s2 = q.ext_s1;
    d.ext_p  = q.ext_s2;
    d.pin_s1 = PORT_PIN_IN;
    d.pin_s2 = q.pin_s1;
    d.pin_p  = q.pin_s2;
    ext_fall = q.ext_p & ~q.ext_s2;
    pin_chg  = (q.pin_s2 ^ q.pin_p) & {q.p3m, q.p1m};

    // current service level
    any_svc = |q.svc;
    cur_lvl = top_level(q.svc);

    // software writes in the data phase
    if (wr) begin
      if (q.bus_idx == IDX_PORT1_WAKE_MASK) begin
        d.p1m = wd;
      end else if (q.bus_idx == IDX_PORT3_WAKE_MASK) begin
        d.p3m = wd;
      end else if (q.bus_idx == IDX_PRIORITY_LOW_MAIN) begin
        d.plm = wd;
      end else if (q.bus_idx == IDX_PRIORITY_HIGH_MAIN) begin
        d.phm = wd;
      end else if (q.bus_idx == IDX_PRIORITY_LOW_EXT) begin
        d.ple = wd;
      end else if (q.bus_idx == IDX_PRIORITY_HIGH_EXT) begin
        d.phe = wd;
      end else if (q.bus_idx == IDX_ENABLE_MAIN) begin
        d.enm = wd;
      end else if (q.bus_idx == IDX_ENABLE_EXT) begin
        d.ene = wd;
      end else if (q.bus_idx == IDX_EXT_CONTROL) begin
        d.xct    = wd;
        clr_e0   = ~wd[XCT_FLAG0_BIT];
        clr_e1   = ~wd[XCT_FLAG1_BIT];
      end else if (q.bus_idx == IDX_INTERRUPT_FLAGS) begin
        clr_rtc = ~wd[FLG_RTC_BIT];
        clr_pnc = ~wd[FLG_PNC_BIT];
        clr_e2  = ~wd[FLG_EXT2_BIT];
      end else if (q.bus_idx == IDX_POWER_CONTROL) begin
        d.pwr = wd & ~(8'h01 << PWR_IDLE_BIT) & ~(8'h01 << PWR_PD_BIT);
      end
    end

    // entry: flags of a serviced pin 2, pin change, rtc or edge-mode pin 0/1 source clear automatically
    if (CPU_ACK_IN && q.req) begin
      d.svc[q.lvl] = 1'b1;
      clr_e0  = clr_e0 | (q.slot == 4'(SLOT_EXT0) && q.xct[XCT_EDGE0_BIT]);
      clr_e1  = clr_e1 | (q.slot == 4'(SLOT_EXT1) && q.xct[XCT_EDGE1_BIT]);
      clr_e2  = clr_e2 | (q.slot == 4'(SLOT_EXT2));
      clr_pnc = clr_pnc | (q.slot == 4'(SLOT_PNC));
      clr_rtc = clr_rtc | (q.slot == 4'(SLOT_RTC));
    end else if (CPU_RETI_IN && any_svc) begin
      d.svc[cur_lvl] = 1'b0;
    end

    // flag setting; a set beats a clear in the same cycle
    set_e0  = q.xct[XCT_EDGE0_BIT] ? ext_fall[0] : ~q.ext_s2[0];
    set_e1  = q.xct[XCT_EDGE1_BIT] ? ext_fall[1] : ~q.ext_s2[1];
    d.ext0f = (q.ext0f & ~clr_e0 & q.xct[XCT_EDGE0_BIT]) | set_e0;
    d.ext1f = (q.ext1f & ~clr_e1 & q.xct[XCT_EDGE1_BIT]) | set_e1;
    d.ext2f = (q.ext2f & ~clr_e2) | ext_fall[2];
    d.pncf  = (q.pncf & ~clr_pnc) | (|pin_chg);
    d.rtcf  = (q.rtcf & ~clr_rtc) | RTC_EVENT_IN;

    // assemble flags in vector order; the reserved slot never requests
    flags[SLOT_EXT0]   = q.ext0f;
    flags[1]           = PERIPH_REQ_IN[0];
    flags[SLOT_EXT1]   = q.ext1f;
    flags[3]           = PERIPH_REQ_IN[1];
    flags[4]           = PERIPH_REQ_IN[2];
    flags[5]           = PERIPH_REQ_IN[3];
    flags[6]           = 1'b0;
    flags[SLOT_RTC]    = q.rtcf;
    flags[SLOT_PNC]    = q.pncf;
    flags[SLOT_EXT2]   = q.ext2f;
    flags[SLOT_EXT2+1] = PERIPH_REQ_IN[4];
    flags[SLOT_EXT2+2] = PERIPH_REQ_IN[5];
    flags[SLOT_EXT2+3] = PERIPH_REQ_IN[6];
    flags[SLOT_PWM]    = PERIPH_REQ_IN[PERIPH_PWM];
    flags[NSLOT-1]     = PERIPH_REQ_IN[8];

    // arbitration: highest level, then lowest vector
    for (int i = 0; i < NSLOT; i++) begin
      pend[i] = flags[i] & slot_bit(q.enm, q.ene, i) & q.enm[EN_GLOBAL_BIT];
      lvl_i   = {slot_bit(q.phm, q.phe, i), slot_bit(q.plm, q.ple, i)};
      if (pend[i] && (!found || lvl_i > best_lvl)) begin
        found    = 1'b1;
        best     = 4'(i);
        best_lvl = lvl_i;
      end
    end

    // request toward the core
    d.req  = found && (!any_svc || best_lvl > cur_lvl)
             && !q.hold && (q.pmode == PM_RUN || q.pmode == PM_IDLE)
             && !(CPU_ACK_IN && q.req);
    d.slot = best;
    d.lvl  = best_lvl;
    d.vec  = 8'(VEC_BASE + {1'b0, best, 3'b000});

    // power modes
    pin_wake  = (q.ext0f & q.enm[SLOT_EXT0]) | (q.ext1f & q.enm[SLOT_EXT1])
              | (q.ext2f & q.ene[SLOT_EXT2-EXT_BASE]) | q.pncf;
    halt_wake = pin_wake | (q.rtcf & q.ene[SLOT_RTC-EXT_BASE])
              | (PERIPH_REQ_IN[PERIPH_PWM] & q.ene[SLOT_PWM-EXT_BASE]);
    refuse    = |(~q.ext_s2 & {q.ene[SLOT_EXT2-EXT_BASE], q.enm[SLOT_EXT1],
                               q.enm[SLOT_EXT0]});
    if (CPU_INSN_DONE_IN) begin
      d.hold = 1'b0;
    end
    case (q.pmode)
      PM_RUN: begin
        if (wr && q.bus_idx == IDX_POWER_CONTROL && wd[PWR_PD_BIT]) begin
          if (!refuse) begin
            d.pmode = q.xct[XCT_SLOWSTOP_BIT] ? PM_STOP : PM_HALT;
          end
        end else if (wr && q.bus_idx == IDX_POWER_CONTROL && wd[PWR_IDLE_BIT]) begin
          d.pmode = PM_IDLE;
        end
      end
      PM_IDLE: begin
        if (|pend) begin
          d.pmode = PM_RUN;
        end
      end
      PM_HALT: begin
        if (halt_wake) begin
          d.pmode = PM_RUN;
          d.hold  = 1'b1;
        end
      end
      PM_STOP: begin
        if (pin_wake) begin
          d.pmode = PM_RUN;
          d.hold  = 1'b1;
        end
      end
      default: begin
        d.pmode = PM_RUN;
      end
    endcase

    // bus address phase; read data is captured here for a zero-wait answer
    d.bus_wr = 1'b0;
    if (HSEL_IN && HTRANS_IN[1] && HREADY_IN) begin
      d.bus_idx = aidx[7:0];
      d.bus_wr  = HWRITE_IN && aidx[9:8] == 2'b00;
      if (HWRITE_IN || aidx[9:8] != 2'b00) begin
        rd = 8'h00;
      end else if (aidx[7:0] == IDX_POWER_CONTROL) begin
        rd = q.pwr | {6'h00, q.pmode == PM_HALT || q.pmode == PM_STOP, q.pmode == PM_IDLE};
      end else if (aidx[7:0] == IDX_INTERRUPT_FLAGS) begin
        rd = {5'h00, q.ext2f, q.pncf, q.rtcf};
      end else if (aidx[7:0] == IDX_PORT1_WAKE_MASK) begin
        rd = q.p1m;
      end else if (aidx[7:0] == IDX_PORT3_WAKE_MASK) begin
        rd = q.p3m;
      end else if (aidx[7:0] == IDX_PRIORITY_LOW_MAIN) begin
        rd = q.plm;
      end else if (aidx[7:0] == IDX_PRIORITY_HIGH_MAIN) begin
        rd = q.phm;
      end else if (aidx[7:0] == IDX_PRIORITY_LOW_EXT) begin
        rd = q.ple;
      end else if (aidx[7:0] == IDX_PRIORITY_HIGH_EXT) begin
        rd = q.phe;
      end else if (aidx[7:0] == IDX_ENABLE_MAIN) begin
        rd = q.enm;
      end else if (aidx[7:0] == IDX_ENABLE_EXT) begin
        rd = q.ene;
      end else if (aidx[7:0] == IDX_EXT_CONTROL) begin
        rd = {q.xct[7:4], q.ext1f, q.ext0f, q.xct[1:0]};
      end else if (aidx[7:0] == IDX_STATUS) begin
        rd = {q.pmode, cur_lvl, any_svc, q.hold, q.req, 1'b0};
      end
      d.rdata = {24'h000000, rd};
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // outputs from state flops; bus ready and response are constants
  // ----------------------------------------------------------------
  assign HRDATA_OUT     = q.rdata;
  assign HREADYOUT_OUT  = 1'b1;
  assign HRESP_OUT      = 1'b0;
  assign IRQ_REQ_OUT    = q.req;
  assign IRQ_VECTOR_OUT = q.vec;
  assign IRQ_LEVEL_OUT  = q.lvl;
  assign CPU_IDLE_OUT   = q.pmode == PM_IDLE;
  assign CPU_HALT_OUT   = q.pmode == PM_HALT;
  assign CPU_STOP_OUT   = q.pmode == PM_STOP;

endmodule
`default_nettype wire

// >>> ivc_properties.sv
// checker: port-level properties of the interrupt and wake-up controller
`default_nettype none
module ivc_properties (
  input wire logic        SYS_CLK_IN,
  input wire logic        RESET_IN,
  input wire logic [31:0] HRDATA_OUT,
  input wire logic        HRESP_OUT,
  input wire logic [2:0]  EXT_PIN_IN,
  input wire logic [15:0] PORT_PIN_IN,
  input wire logic        CPU_ACK_IN,
  input wire logic        CPU_RETI_IN,
  input wire logic        IRQ_REQ_OUT,
  input wire logic [7:0]  IRQ_VECTOR_OUT,
  input wire logic [1:0]  IRQ_LEVEL_OUT,
  input wire logic        CPU_IDLE_OUT,
  input wire logic        CPU_HALT_OUT,
  input wire logic        CPU_STOP_OUT
);
  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (RESET_IN);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  property p_ack_clears;
    CPU_ACK_IN && IRQ_REQ_OUT |=> !IRQ_REQ_OUT;
  endproperty
  a_ack_clears: assert property (p_ack_clears) else $error("request kept after ack");
  property p_vector_map;
    IRQ_REQ_OUT |-> IRQ_VECTOR_OUT[2:0] == 3'h3 && IRQ_VECTOR_OUT <= 8'h73
                    && IRQ_VECTOR_OUT != 8'h33;
  endproperty
  a_vector_map: assert property (p_vector_map) else $error("bad vector");
  property p_one_mode;
    $onehot0({CPU_IDLE_OUT, CPU_HALT_OUT, CPU_STOP_OUT});
  endproperty
  a_one_mode: assert property (p_one_mode) else $error("two power modes");
  // the core needs one instruction before any entry after power-down
  property p_wake_hold;
    $fell(CPU_HALT_OUT) || $fell(CPU_STOP_OUT) |-> (!IRQ_REQ_OUT) [*2];
  endproperty
  a_wake_hold: assert property (p_wake_hold) else $error("entry before insn");
  property p_idle_entry;
    $fell(CPU_IDLE_OUT) |-> ##[0:3] IRQ_REQ_OUT;
  endproperty
  a_idle_entry: assert property (p_idle_entry) else $error("idle exit no request");
  sequence s_pins_quiet;
    (CPU_STOP_OUT && EXT_PIN_IN == 3'h7 && $stable(PORT_PIN_IN)) [*5];
  endsequence
  property p_stop_pins;
    s_pins_quiet |=> CPU_STOP_OUT;
  endproperty
  a_stop_pins: assert property (p_stop_pins) else $error("stop left without pin");
  property p_top_blocks;
    (IRQ_REQ_OUT && CPU_ACK_IN && IRQ_LEVEL_OUT == 2'h3) ##1 (!CPU_RETI_IN) [*3]
      |-> !IRQ_REQ_OUT;
  endproperty
  a_top_blocks: assert property (p_top_blocks) else $error("top level preempted");
  property p_bus_okay;
    !HRESP_OUT && HRDATA_OUT[31:8] == 24'h000000;
  endproperty
  a_bus_okay: assert property (p_bus_okay) else $error("bus response or data bad");
  c_top: cover property (IRQ_REQ_OUT && CPU_ACK_IN && IRQ_LEVEL_OUT == 2'h3);
  c_idle: cover property ($fell(CPU_IDLE_OUT));
  c_stop: cover property ($fell(CPU_STOP_OUT));
endmodule
bind ivc_ctrl ivc_properties i_ivc_properties (
  .SYS_CLK_IN(SYS_CLK_IN), .RESET_IN(RESET_IN), .HRDATA_OUT(HRDATA_OUT),
  .HRESP_OUT(HRESP_OUT), .EXT_PIN_IN(EXT_PIN_IN), .PORT_PIN_IN(PORT_PIN_IN),
  .CPU_ACK_IN(CPU_ACK_IN), .CPU_RETI_IN(CPU_RETI_IN), .IRQ_REQ_OUT(IRQ_REQ_OUT),
  .IRQ_VECTOR_OUT(IRQ_VECTOR_OUT), .IRQ_LEVEL_OUT(IRQ_LEVEL_OUT),
  .CPU_IDLE_OUT(CPU_IDLE_OUT), .CPU_HALT_OUT(CPU_HALT_OUT), .CPU_STOP_OUT(CPU_STOP_OUT)
);
`default_nettype wire

// >>> ivc_cpu_model.sv
// model: core side that takes vectors and retires instructions after wake
`default_nettype none
module ivc_cpu_model (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       req,
  input  wire logic [7:0] vec,
  input  wire logic       halt,
  input  wire logic       stop,
  input  wire logic [3:0] dly,
  output logic            ack,
  output logic            insn,
  output logic [7:0]      last_vec,
  output int              ack_cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_q;
  logic [2:0] wake_q;
  logic       sleep_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      {ack, insn, sleep_q, wait_q, wake_q, last_vec} <= '0;
      ack_cnt <= 0;
    end else begin
      ack <= 1'b0;
      // slow or prompt answer, as the bench asks
      if (req && !ack) begin
        if (wait_q >= dly) begin
          ack    <= 1'b1;
          wait_q <= 4'h0;
        end else begin
          wait_q <= wait_q + 4'h1;
        end
      end else begin
        wait_q <= 4'h0;
      end
      if (ack && req) begin
        last_vec <= vec;
        ack_cnt  <= ack_cnt + 1;
      end
      sleep_q <= halt | stop;
      insn    <= (wake_q == 3'h1);
      if (sleep_q && !halt && !stop) begin
        wake_q <= 3'h4;
      end else if (wake_q != 3'h0) begin
        wake_q <= wake_q - 3'h1;
      end
    end
  end
endmodule
`default_nettype wire

// >>> test_interrupt_wakeup_controller.sv
// testbench: register, vector, priority and power-mode checks of the controller
`default_nettype none
module test_interrupt_wakeup_controller
  import ivc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] RG [8] = '{IDX_POWER_CONTROL, IDX_INTERRUPT_FLAGS,
    IDX_PORT1_WAKE_MASK, IDX_PORT3_WAKE_MASK, IDX_PRIORITY_LOW_MAIN,
    IDX_PRIORITY_HIGH_MAIN, IDX_PRIORITY_LOW_EXT, IDX_PRIORITY_HIGH_EXT};
  localparam logic [7:0] PV [9] = '{8'h0B, 8'h1B, 8'h23, 8'h2B, 8'h53, 8'h5B, 8'h63,
    8'h6B, 8'h73};
  localparam logic [7:0] XV [3] = '{8'h03, 8'h13, 8'h4B};
  logic        clk, rst, hsel, hwrite, hready, hresp, rtc_ev, ack, reti, insn;
  logic        irq, idle, halt, stop;
  logic [1:0]  htrans, lvl;
  logic [11:0] haddr;
  logic [31:0] hwdata, hrdata;
  logic [2:0]  ext_pin;
  logic [15:0] port_pin;
  logic [8:0]  periph;
  logic [7:0]  vec, last_vec, rd;
  logic [3:0]  dly;
  int          ack_cnt, errors, comparisons;
  ivc_ctrl i_ivc_ctrl (.SYS_CLK_IN(clk), .RESET_IN(rst), .HSEL_IN(hsel), .HADDR_IN(haddr),
    .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(3'h2), .HWDATA_IN(hwdata),
    .HREADY_IN(hready), .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready), .HRESP_OUT(hresp),
    .EXT_PIN_IN(ext_pin), .PORT_PIN_IN(port_pin), .PERIPH_REQ_IN(periph),
    .RTC_EVENT_IN(rtc_ev), .CPU_ACK_IN(ack), .CPU_RETI_IN(reti), .CPU_INSN_DONE_IN(insn),
    .IRQ_REQ_OUT(irq), .IRQ_VECTOR_OUT(vec), .IRQ_LEVEL_OUT(lvl), .CPU_IDLE_OUT(idle),
    .CPU_HALT_OUT(halt), .CPU_STOP_OUT(stop));
  ivc_cpu_model i_ivc_cpu_model (.clk(clk), .rst(rst), .req(irq), .vec(vec), .halt(halt),
    .stop(stop), .dly(dly), .ack(ack), .insn(insn), .last_vec(last_vec), .ack_cnt(ack_cnt));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("comparisons=%0d errors=%0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // single word transfer; byte address is four times the register index
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] wd);
    @(posedge clk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {2'h0, idx, 2'h0};
    do @(posedge clk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h000000, wd};
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata[7:0];
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d);
  endtask
  task automatic rc(input logic [7:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00);
    chk(rd, exp);
  endtask
  task automatic take(input logic [7:0] v);
    int n;
    int k;
    n = ack_cnt;
    k = 0;
    while (ack_cnt == n && k < 300) begin
      @(posedge clk);
      k++;
    end
    #1;
    chk(8'(ack_cnt - n), 8'h01);
    chk(last_vec, v);
  endtask
  task automatic quiet(input int c);
    int n;
    n = ack_cnt;
    wt(c);
    chk(8'(ack_cnt - n), 8'h00);
  endtask
  task automatic reti_p();
    @(posedge clk);
    reti <= 1'b1;
    @(posedge clk);
    reti <= 1'b0;
  endtask
  task automatic rtc_p();
    @(posedge clk);
    rtc_ev <= 1'b1;
    @(posedge clk);
    rtc_ev <= 1'b0;
  endtask
  // ----------------------------------------------------------------
  // stimulus
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #100000;
    errors++;
    end_sim();
  end
  initial begin
    {rst, hsel, hwrite, rtc_ev, reti} = 5'h10;
    {htrans, haddr, hwdata, periph} = '0;
    ext_pin  = 3'h7;
    port_pin = 16'h0000;
    dly      = 4'h0;
    errors = 0;
    comparisons = 0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    foreach (RG[i]) rc(RG[i], 8'h00);
    rc(8'h10, 8'h00);
    for (int i = 2; i < 8; i++) begin
      wr(RG[i], 8'hA5 ^ 8'(i));
      rc(RG[i], 8'hA5 ^ 8'(i));
      wr(RG[i], 8'h00);
    end
    // flags set with every enable off
    rtc_p();
    rc(IDX_INTERRUPT_FLAGS, 8'h01);
    wr(IDX_PORT1_WAKE_MASK, 8'h04);
    port_pin[2] <= 1'b1;
    wt(6);
    rc(IDX_INTERRUPT_FLAGS, 8'h03);
    ext_pin[2] <= 1'b0;
    wt(6);
    rc(IDX_INTERRUPT_FLAGS, 8'h07);
    wr(IDX_INTERRUPT_FLAGS, 8'hFD);
    rc(IDX_INTERRUPT_FLAGS, 8'h05);
    wr(IDX_INTERRUPT_FLAGS, 8'hFB);
    rc(IDX_INTERRUPT_FLAGS, 8'h01);
    wr(IDX_INTERRUPT_FLAGS, 8'hFE);
    rc(IDX_INTERRUPT_FLAGS, 8'h00);
    ext_pin[2] <= 1'b1;
    // global enable gates a pending request
    wr(IDX_ENABLE_MAIN, 8'h3F);
    wr(IDX_ENABLE_EXT, 8'hFE);
    periph <= 9'h001;
    quiet(10);
    wr(IDX_ENABLE_MAIN, 8'hBF);
    take(PV[0]);
    periph <= 9'h000;
    reti_p();
    dly <= 4'h6;
    for (int i = 1; i < 9; i++) begin
      periph <= 9'h001 << i;
      take(PV[i]);
      periph <= 9'h000;
      reti_p();
    end
    dly <= 4'h0;
    for (int i = 0; i < 3; i++) begin
      ext_pin[i] <= 1'b0;
      take(XV[i]);
      ext_pin[i] <= 1'b1;
      wt(4);
      reti_p();
    end
    wr(IDX_PORT1_WAKE_MASK, 8'h01);
    port_pin[0] <= 1'b1;
    take(8'h43);
    rc(IDX_INTERRUPT_FLAGS, 8'h00);
    reti_p();
    // level 2 beats level 1 despite the higher vector
    wr(IDX_PRIORITY_LOW_MAIN, 8'h02);
    wr(IDX_PRIORITY_HIGH_MAIN, 8'h08);
    periph <= 9'h003;
    take(PV[1]);
    periph <= 9'h001;
    reti_p();
    take(PV[0]);
    periph <= 9'h000;
    reti_p();
    wr(IDX_PRIORITY_LOW_MAIN, 8'h00);
    wr(IDX_PRIORITY_HIGH_MAIN, 8'h00);
    wr(IDX_PRIORITY_LOW_EXT, 8'h80);
    wr(IDX_PRIORITY_HIGH_EXT, 8'h80);
    periph <= 9'h003;
    take(PV[0]);
    periph <= 9'h002;
    quiet(10);
    periph <= 9'h102;
    take(PV[8]);
    chk({6'h00, lvl}, 8'h03);
    periph <= 9'h002;
    wt(4);
    reti_p();
    quiet(10);
    reti_p();
    take(PV[1]);
    periph <= 9'h000;
    reti_p();
    // idle: waits for the global enable, then enters at once
    wr(IDX_ENABLE_EXT, 8'hFF);
    wr(IDX_ENABLE_MAIN, 8'h3F);
    wr(IDX_POWER_CONTROL, 8'h01);
    wt(2);
    chk({5'h00, idle, halt, stop}, 8'h04);
    rtc_p();
    wt(8);
    chk({5'h00, idle, halt, stop}, 8'h04);
    wr(IDX_ENABLE_MAIN, 8'hBF);
    take(8'h3B);
    chk({5'h00, idle, halt, stop}, 8'h00);
    rc(IDX_INTERRUPT_FLAGS, 8'h00);
    reti_p();
    wr(IDX_POWER_CONTROL, 8'h02);
    wt(2);
    chk({5'h00, idle, halt, stop}, 8'h02);
    rtc_p();
    take(8'h3B);
    reti_p();
    // stop: only the pin wakes, no entry without the global enable
    wr(IDX_EXT_CONTROL, 8'h10);
    wr(IDX_ENABLE_MAIN, 8'h01);
    wr(IDX_POWER_CONTROL, 8'h02);
    wt(2);
    chk({5'h00, idle, halt, stop}, 8'h01);
    rtc_p();
    wt(8);
    chk({5'h00, idle, halt, stop}, 8'h01);
    ext_pin[0] <= 1'b0;
    wt(8);
    chk({5'h00, idle, halt, stop}, 8'h00);
    quiet(10);
    wr(IDX_POWER_CONTROL, 8'h02);
    wt(2);
    chk({5'h00, idle, halt, stop}, 8'h00);
    ext_pin[0] <= 1'b1;
    wt(4);
    end_sim();
  end
endmodule
`default_nettype wire
